/* File: rtl/mdio_in_chan.sv */
`timescale 1ns/1ps
module mdio_in_chan #(
	parameter bit ON_BASE = 1'b1
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	input wire logic tick_ms,
	// configuration
	input wire logic invert,
	input wire logic [mdio_pkg::DEB_W-1:0] debounce_ms,
	input wire mdio_pkg::mdio_mode_e mode,
	input wire logic clock_uses_time,
	input wire logic count_clear,
	// port
	input wire logic port_in,
	// results
	output logic state,
	output logic [mdio_pkg::CNT_W-1:0] count,
	output logic time_code,
	output logic mode_rejected
);
	logic stable_q, stable_d;
	logic [mdio_pkg::DEB_W-1:0] held_q, held_d;
	logic half_q, half_d;
	logic [mdio_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [7:0] ac_q, ac_d;
	logic state_q, state_d;
	logic tc_q, tc_d;
	logic rej_q, rej_d;
	logic lvl;
	logic accept;

	always_comb begin
		lvl = port_in ^ invert;
		accept = 1'b0;
		held_d = held_q;
		stable_d = stable_q;
		if (lvl == stable_q) begin
			held_d = '0;
		end else if (debounce_ms == '0 || held_q > debounce_ms) begin
			// one tick more than set: the first tick may fall right after the change
			accept = 1'b1;
			stable_d = lvl;
			held_d = '0;
		end else if (tick_ms) begin
			held_d = held_q + 1'b1;
		end
		rej_d = (mode == mdio_pkg::MDIO_MODE_TIME) && !ON_BASE;
		half_d = half_q;
		cnt_d = cnt_q;
		ac_d = ac_q;
		state_d = stable_q;
		tc_d = 1'b0;
		case (mode)
			mdio_pkg::MDIO_MODE_PULSE: begin
				if (accept && lvl) begin
					half_d = 1'b1;
				end else if (accept && half_q) begin
					half_d = 1'b0;
					cnt_d = cnt_q + 1'b1;
				end
			end
			mdio_pkg::MDIO_MODE_TRANS: begin
				if (accept) begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			mdio_pkg::MDIO_MODE_AC: begin
				if (accept) begin
					ac_d = mdio_pkg::AC_HOLD_MS;
				end else if (tick_ms && ac_q != '0) begin
					ac_d = ac_q - 1'b1;
				end
				state_d = (ac_d != '0);
			end
			mdio_pkg::MDIO_MODE_TIME: begin
				// decoding lives elsewhere; only a qualified level is handed on
				tc_d = ON_BASE && clock_uses_time && stable_q;
			end
			default: begin
				state_d = stable_q;
			end
		endcase
		if (count_clear) begin
			cnt_d = '0;
			// a rise accepted in the same cycle survives the clear
			half_d = half_d & ~half_q;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stable_q <= 1'b0;
			held_q <= '0;
			half_q <= 1'b0;
			cnt_q <= '0;
			ac_q <= '0;
			state_q <= 1'b0;
			tc_q <= 1'b0;
			rej_q <= 1'b0;
		end else begin
			stable_q <= stable_d;
			held_q <= held_d;
			half_q <= half_d;
			cnt_q <= cnt_d;
			ac_q <= ac_d;
			state_q <= state_d;
			tc_q <= tc_d;
			rej_q <= rej_d;
		end
	end

	assign state = state_q;
	assign count = cnt_q;
	assign time_code = tc_q;
	assign mode_rejected = rej_q;
endmodule

/* File: rtl/mdio_pkg.sv */
package mdio_pkg;
	// system clock and prescaled ticks
	localparam int CLK_HZ = 10000000;
	localparam int MS_PER_S = 1000;
	localparam int TICK_MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int TICK_S_MS = 1000;
	localparam int MS_CNT_W = 14;
	localparam int S_CNT_W = 10;
	// debounce 0.000 .. 1.000 s in ms
	localparam int DEB_W = 10;
	localparam logic [DEB_W-1:0] DEB_MAX_MS = 10'h3E8;
	// force-on duration 0 .. 2,000,000 s
	localparam int DUR_W = 21;
	localparam logic [DUR_W-1:0] DUR_MAX_S = 21'h1E8480;
	localparam int CNT_W = 32;
	// ac presence: on if a change was seen within this many ms
	localparam logic [7:0] AC_HOLD_MS = 8'h28;
	localparam int NUM_IN = 4;

	typedef enum logic [1:0] {
		MDIO_MODE_PULSE = 2'h0,
		MDIO_MODE_TRANS = 2'h1,
		MDIO_MODE_AC = 2'h3,
		MDIO_MODE_TIME = 2'h2
	} mdio_mode_e;

	typedef enum logic [1:0] {
		MDIO_OUT_SOURCE = 2'h0,
		MDIO_OUT_FON = 2'h1,
		MDIO_OUT_LATCH = 2'h3,
		MDIO_OUT_FOFF = 2'h2
	} mdio_ostate_e;
endpackage

/* File: rtl/mdio_top.sv */
`timescale 1ns/1ps
module mdio_top (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// input ports and their configuration
	input wire logic [mdio_pkg::NUM_IN-1:0] in_port,
	input wire logic [mdio_pkg::NUM_IN-1:0] in_invert,
	input wire logic [mdio_pkg::NUM_IN*mdio_pkg::DEB_W-1:0] in_debounce_ms,
	input wire logic [mdio_pkg::NUM_IN*2-1:0] in_mode,
	input wire logic [mdio_pkg::NUM_IN-1:0] in_on_base,
	input wire logic [mdio_pkg::NUM_IN-1:0] in_count_clear,
	input wire logic clock_uses_time,
	// input results
	output logic [mdio_pkg::NUM_IN-1:0] in_state,
	output logic [mdio_pkg::NUM_IN*mdio_pkg::CNT_W-1:0] in_count,
	output logic [mdio_pkg::NUM_IN-1:0] in_time_code,
	output logic [mdio_pkg::NUM_IN-1:0] in_mode_rejected,
	// output control
	input wire logic source_linked,
	input wire logic source_value,
	input wire logic force_on,
	input wire logic force_off,
	input wire logic normal,
	input wire logic out_invert,
	input wire logic [mdio_pkg::DUR_W-1:0] force_on_duration,
	// output port and status
	output logic out_port,
	output logic out_state,
	output logic out_forced
);
	logic [mdio_pkg::MS_CNT_W-1:0] pre_q, pre_d;
	logic [mdio_pkg::S_CNT_W-1:0] msc_q, msc_d;
	logic tick_ms_q, tick_ms_d;
	logic tick_s_q, tick_s_d;
	mdio_pkg::mdio_ostate_e os_q, os_d;
	logic [mdio_pkg::DUR_W-1:0] dur_q, dur_d;
	logic [mdio_pkg::DUR_W-1:0] rem_q, rem_d;
	logic port_q, port_d;
	logic st_q, st_d;
	logic frc_q, frc_d;
	logic [mdio_pkg::NUM_IN-1:0] st_w, tc_w, rej_w;
	logic [mdio_pkg::NUM_IN*mdio_pkg::CNT_W-1:0] cnt_w;
	logic [mdio_pkg::NUM_IN-1:0] st_oq, tc_oq, rej_oq;
	logic [mdio_pkg::NUM_IN*mdio_pkg::CNT_W-1:0] cnt_oq;

	// a zero duration selects latch-on and unlocks force-off and normal
	function automatic logic dur_zero(input logic [mdio_pkg::DUR_W-1:0] d);
		return d == '0;
	endfunction

	function automatic logic [1:0] mode_sel(input logic [mdio_pkg::NUM_IN*2-1:0] m, input int i);
		return m[2*i +: 2];
	endfunction

	// settings above range clip to the top of the range
	function automatic logic [mdio_pkg::DUR_W-1:0] dur_clip(input logic [mdio_pkg::DUR_W-1:0] d);
		return (d > mdio_pkg::DUR_MAX_S) ? mdio_pkg::DUR_MAX_S : d;
	endfunction

	// prescaler: 1 ms and 1 s enables
	always_comb begin
		pre_d = pre_q + 1'b1;
		msc_d = msc_q;
		tick_ms_d = 1'b0;
		tick_s_d = 1'b0;
		if (pre_q == mdio_pkg::MS_CNT_W'(mdio_pkg::TICK_MS_CYCLES - 1)) begin
			pre_d = '0;
			tick_ms_d = 1'b1;
			msc_d = msc_q + 1'b1;
			if (msc_q == mdio_pkg::S_CNT_W'(mdio_pkg::TICK_S_MS - 1)) begin
				msc_d = '0;
				tick_s_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pre_q <= '0;
			msc_q <= '0;
			tick_ms_q <= 1'b0;
			tick_s_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			msc_q <= msc_d;
			tick_ms_q <= tick_ms_d;
			tick_s_q <= tick_s_d;
		end
	end

	for (genvar i = 0; i < mdio_pkg::NUM_IN; i++) begin : g_in
		logic [mdio_pkg::DEB_W-1:0] deb;
		always_comb begin
			deb = in_debounce_ms[i*mdio_pkg::DEB_W +: mdio_pkg::DEB_W];
			// out-of-range settings clip to one second
			if (deb > mdio_pkg::DEB_MAX_MS) begin
				deb = mdio_pkg::DEB_MAX_MS;
			end
		end
		mdio_in_chan #(.ON_BASE(1'b1)) u_chan (
			.clock(clock),
			.resetn(resetn),
			.tick_ms(tick_ms_q),
			.invert(in_invert[i]),
			.debounce_ms(deb),
			.mode(mdio_pkg::mdio_mode_e'(mode_sel(in_mode, i))),
			.clock_uses_time(clock_uses_time & in_on_base[i]),
			.count_clear(in_count_clear[i]),
			.port_in(in_port[i]),
			.state(st_w[i]),
			.count(cnt_w[i*mdio_pkg::CNT_W +: mdio_pkg::CNT_W]),
			.time_code(tc_w[i]),
			.mode_rejected()
		);
		// rejection of option-module inputs uses the per-port base flag
		assign rej_w[i] = (mode_sel(in_mode, i) == 2'(mdio_pkg::MDIO_MODE_TIME)) && !in_on_base[i];
	end

	// output stage
	always_comb begin
		os_d = os_q;
		rem_d = rem_q;
		dur_d = dur_clip(force_on_duration);
		if (force_on) begin
			if (dur_zero(dur_q)) begin
				os_d = mdio_pkg::MDIO_OUT_LATCH;
			end else begin
				os_d = mdio_pkg::MDIO_OUT_FON;
				rem_d = dur_q;
			end
		end else if (dur_zero(dur_q) && force_off) begin
			os_d = mdio_pkg::MDIO_OUT_FOFF;
		end else if (dur_zero(dur_q) && normal && (os_q == mdio_pkg::MDIO_OUT_LATCH
				|| os_q == mdio_pkg::MDIO_OUT_FON)) begin
			// force-off is left only by the next force-on
			os_d = mdio_pkg::MDIO_OUT_SOURCE;
		end else if (os_q == mdio_pkg::MDIO_OUT_FON && tick_s_q) begin
			// free-running tick: the first second may be short
			if (rem_q <= mdio_pkg::DUR_W'(1)) begin
				os_d = mdio_pkg::MDIO_OUT_SOURCE;
				rem_d = '0;
			end else begin
				rem_d = rem_q - 1'b1;
			end
		end
		case (os_q)
			mdio_pkg::MDIO_OUT_SOURCE: begin
				// unlinked output keeps off until forced
				st_d = source_linked ? source_value : 1'b0;
			end
			mdio_pkg::MDIO_OUT_FON: begin
				st_d = 1'b1;
			end
			mdio_pkg::MDIO_OUT_LATCH: begin
				st_d = 1'b1;
			end
			mdio_pkg::MDIO_OUT_FOFF: begin
				st_d = 1'b0;
			end
			default: begin
				st_d = 1'b0;
			end
		endcase
		frc_d = (os_q != mdio_pkg::MDIO_OUT_SOURCE);
		port_d = st_d ^ out_invert;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			os_q <= mdio_pkg::MDIO_OUT_SOURCE;
			dur_q <= '0;
			rem_q <= '0;
			st_q <= 1'b0;
			port_q <= 1'b0;
			frc_q <= 1'b0;
		end else begin
			os_q <= os_d;
			dur_q <= dur_d;
			rem_q <= rem_d;
			st_q <= st_d;
			port_q <= port_d;
			frc_q <= frc_d;
		end
	end

	// input results registered so every top output leaves a flip-flop
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_oq <= '0;
			cnt_oq <= '0;
			tc_oq <= '0;
			rej_oq <= '0;
		end else begin
			st_oq <= st_w;
			cnt_oq <= cnt_w;
			tc_oq <= tc_w;
			rej_oq <= rej_w;
		end
	end

	assign out_port = port_q;
	assign out_state = st_q;
	assign out_forced = frc_q;
	assign in_state = st_oq;
	assign in_count = cnt_oq;
	assign in_time_code = tc_oq;
	assign in_mode_rejected = rej_oq;
endmodule

/* File: tb/mdio_contact.sv */
`timescale 1ns/1ps
module mdio_contact (
	// clock
	input wire logic clock,
	// wanted contact levels
	input wire logic chatter,
	input wire logic [3:0] level,
	// contact outputs
	output logic [3:0] port
);
	logic [3:0] last = 4'h0;
	logic [3:0] chg = 4'h0;
	int n = 0;
	initial port = 4'h0;
	// only moving contacts chatter, so steady ones stay quiet
	always @(posedge clock) begin
		last <= level;
		if (level != last) begin
			chg <= level ^ last;
			n <= chatter ? 6 : 0;
		end else if (n > 0) begin
			n <= n - 1;
		end
		port <= (n[0] && n > 1) ? level ^ chg : level;
	end
endmodule

/* File: tb/mdio_monitor.sv */
`timescale 1ns/1ps
module mdio_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// input side
	input wire logic [7:0] in_mode,
	input wire logic [3:0] in_on_base,
	input wire logic clock_uses_time,
	input wire logic [3:0] in_time_code,
	input wire logic [3:0] in_mode_rejected,
	input wire logic [127:0] in_count,
	// output side
	input wire logic source_linked,
	input wire logic source_value,
	input wire logic force_on,
	input wire logic force_off,
	input wire logic normal,
	input wire logic out_invert,
	input wire logic [20:0] force_on_duration,
	input wire logic out_port,
	input wire logic out_state,
	input wire logic out_forced
);
	logic [3:0] rej;
	logic [31:0] c0;
	assign c0 = in_count[31:0];
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rej[i] = in_mode[2*i+:2] == 2'h2 && !in_on_base[i];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_cfg;
		($stable(in_mode) && $stable(in_on_base) && $stable(clock_uses_time))[*3];
	endsequence
	// the setting is registered a cycle late, so it must be steady
	sequence s_dur0;
		force_on_duration == 21'h0 && $stable(force_on_duration) && !force_on;
	endsequence
	property p_port;
		$past(resetn, 2) && $stable(out_invert) |-> out_port == (out_state ^ out_invert);
	endproperty
	property p_fon;
		force_on |-> ##2 out_state && out_forced;
	endproperty
	property p_foff;
		s_dur0 ##0 force_off |-> ##2 !out_state && out_forced;
	endproperty
	property p_norm;
		s_dur0 ##0 normal && !force_off && out_state && out_forced && !$past(force_off)
			&& !$past(force_on) |-> ##2 !out_forced;
	endproperty
	property p_link;
		!out_forced && !$past(out_forced) && $past(resetn, 3)
			|-> out_state == ($past(source_linked) && $past(source_value));
	endproperty
	property p_rej;
		s_cfg |-> in_mode_rejected == rej;
	endproperty
	property p_tc;
		s_cfg |-> (in_time_code & (rej | {4{!clock_uses_time}})) == 4'h0;
	endproperty
	property p_cnt;
		$changed(c0) |-> c0 == $past(c0) + 32'h1 || c0 == 32'h0;
	endproperty
	a_port: assert property (p_port) else $error("port polarity wrong");
	a_fon: assert property (p_fon) else $error("force on missed");
	a_foff: assert property (p_foff) else $error("force off missed");
	a_norm: assert property (p_norm) else $error("normal missed");
	a_link: assert property (p_link) else $error("source not followed");
	a_rej: assert property (p_rej) else $error("rejection wrong");
	a_tc: assert property (p_tc) else $error("time code leaked");
	a_cnt: assert property (p_cnt) else $error("count jumped");
endmodule
bind mdio_top mdio_monitor mdio_monitor_i (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] level = 4'h0;
	logic chatter = 1'b0;
	logic [2:0] fp = 3'h0;
	logic [3:0] in_port, in_invert = 4'h2, in_on_base = 4'hF, in_count_clear = 4'h0;
	logic [39:0] in_debounce_ms = {10'h0, 10'h1, 10'h0, 10'h0};
	logic [7:0] in_mode = {2'h3, 2'h1, 2'h1, 2'h0};
	logic clock_uses_time = 1'b0, source_linked = 1'b0, source_value = 1'b0, out_invert = 1'b0;
	logic [20:0] force_on_duration = 21'h0;
	logic [3:0] in_state, in_time_code, in_mode_rejected;
	logic [127:0] in_count;
	logic out_port, out_state, out_forced;
	int errors = 0;
	int checks_done = 0;
	always #50 clock = ~clock;
	mdio_contact mdio_contact_i (.clock(clock), .chatter(chatter), .level(level), .port(in_port));
	mdio_top mdio_top_i (.*, .force_on(fp[0]), .force_off(fp[1]), .normal(fp[2]));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic drive(input logic [3:0] l, input int n);
		@(posedge clock);
		level <= l;
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge clock);
		fp <= m;
		@(posedge clock);
		fp <= 3'h0;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		in_count_clear <= 4'hF;
		@(posedge clock);
		in_count_clear <= 4'h0;
		for (int i = 1; i <= 3; i++) begin
			drive(4'h3, 8);
			chk("half pulse count", i - 1, in_count[31:0]);
			drive(4'h0, 8);
			chk("pulse count", i, in_count[31:0]);
			chk("transition count", 2 * i, in_count[63:32]);
		end
		chk("inverted state", 4'h2, in_state);
		$display("test counting done");
		// chatter far shorter than 1 ms must not count
		chatter <= 1'b1;
		drive(4'h4, 5000);
		chk("early state", 4'h0, in_state & 4'h4);
		drive(4'h4, 25000);
		chk("debounced state", 4'h4, in_state & 4'h4);
		chk("debounced count", 1, in_count[95:64]);
		chatter <= 1'b0;
		for (int i = 0; i < 20; i++) begin
			drive(level ^ 4'h8, 10);
		end
		chk("ac presence", 4'h8, in_state & 4'h8);
		$display("test debounce done");
		@(posedge clock);
		in_mode <= 8'h96;
		in_on_base <= 4'h7;
		clock_uses_time <= 1'b1;
		drive(4'h5, 8);
		chk("time code", 4'h1, in_time_code);
		chk("rejected", 4'h8, in_mode_rejected);
		@(posedge clock);
		clock_uses_time <= 1'b0;
		drive(level, 6);
		chk("time code off", 4'h0, in_time_code);
		$display("test time code done");
		@(posedge clock);
		source_linked <= 1'b1;
		source_value <= 1'b1;
		out_invert <= 1'b1;
		drive(level, 4);
		chk("linked state", 1, out_state);
		chk("inverted port", 0, out_port);
		pulse(3'h2);
		chk("force off", 0, out_state);
		@(posedge clock);
		source_value <= 1'b0;
		pulse(3'h1);
		chk("latched on", 1, out_state);
		pulse(3'h4);
		chk("normal", 2'h0, {out_state, out_forced});
		@(posedge clock);
		source_linked <= 1'b0;
		source_value <= 1'b1;
		drive(level, 4);
		chk("unlinked", 0, out_state);
		@(posedge clock);
		force_on_duration <= mdio_pkg::DUR_MAX_S;
		drive(level, 3);
		pulse(3'h1);
		chk("timed on", 1, out_state);
		pulse(3'h2);
		pulse(3'h4);
		chk("ignored pulses", 2'h3, {out_state, out_forced});
		$display("test output done");
		complete_run();
	end
endmodule
